/* File: logic/asc_pkg.sv */
// Purpose: constants and types for the asynchronous sram host controller
// Assumes: 100 MHz clock, 10 ns period
// Notes:   times in ns/us as printed, cycle counts derived
package asc_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W        = 17;
    localparam int DATA_W        = 16;

    // ---------------------------------------------------------------
    // speed grade times, slow grade kept so both grades are safe
    // ---------------------------------------------------------------
    localparam int WRITE_DATA_SETUP_NS      = 6;
    localparam int STROBE_TO_FLOAT_DELAY_NS = 6;
    localparam int ENABLE_TO_WRITE_END_NS   = 8;
    localparam int LANE_ENABLE_ACCESS_NS    = 7;
    localparam int ADDRESS_TO_DATA_NS       = 12;
    localparam int OUTPUT_FLOAT_NS          = 6;
    localparam int RETENTION_RECOVERY_NS    = 12;
    localparam int POWER_UP_WAIT_US         = 100;

    function automatic int ceil_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ceil_cycles

    localparam int WR_LOW_CYC   = ceil_cycles(
        (WRITE_DATA_SETUP_NS + STROBE_TO_FLOAT_DELAY_NS > ENABLE_TO_WRITE_END_NS)
        ? WRITE_DATA_SETUP_NS + STROBE_TO_FLOAT_DELAY_NS : ENABLE_TO_WRITE_END_NS);
    localparam int RD_WAIT_CYC  = ceil_cycles(
        (ADDRESS_TO_DATA_NS > LANE_ENABLE_ACCESS_NS) ? ADDRESS_TO_DATA_NS : LANE_ENABLE_ACCESS_NS) + 1;
    localparam int FLOAT_CYC    = ceil_cycles(OUTPUT_FLOAT_NS);
    localparam int RECOVER_CYC  = ceil_cycles(RETENTION_RECOVERY_NS);
    localparam int POWER_UP_CYC = POWER_UP_WAIT_US * 1000 / CLK_PERIOD_NS;

    localparam int CNT_W = 17;

    typedef enum logic [2:0] {
        ASC_POWER_UP = 3'b000,
        ASC_IDLE     = 3'b001,
        ASC_READ     = 3'b010,
        ASC_WRITE    = 3'b011,
        ASC_TURN     = 3'b100,
        ASC_RETAIN   = 3'b101,
        ASC_RECOVER  = 3'b110
    } asc_state_t;

endpackage : asc_pkg

/* File: logic/asc_delay_cnt.sv */
// Purpose: loadable down counter flagging expiry of a wait
// Assumes: load and count are synchronous
// Notes:   done is registered, high once count reaches zero (low after reset)
`timescale 1ns/1ns
module asc_delay_cnt (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   load,
    input  wire logic [asc_pkg::CNT_W-1:0] value,
    output logic                        done
);
    import asc_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } asc_cnt_t;

    asc_cnt_t r;
    asc_cnt_t next_r;

    always_comb begin
        next_r = r;
        if (load) begin
            next_r.cnt  = value;
            next_r.done = (value == '0);
        end else if (r.cnt != '0) begin
            next_r.cnt  = r.cnt - 1'b1;
            next_r.done = (r.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done = r.done;
endmodule : asc_delay_cnt

/* File: logic/asc_sram_host.sv */
// Purpose: host controller sequencing reads, writes, power-up and retention
// Assumes: synchronous user inputs; sram pins sampled on clk
// Notes:   timings taken from the slower grade so both grades work
//
// Functional notes
// - write needs strobe, select, lane low together
// - write ends at first rising control edge
// - data set up before write-ending edge
// - data held through write-ending edge
// - address valid by write start
// - address set up before write end
// - address held through write end
// - select low long enough before end
// - lane enable low long before end
// - strobe pulse covers setup plus float
// - wait 100 us after supply stable
// - deselect before supply drops to retention
// - wait recovery time after retention exit
// - write strobe high during reads
// - lane enables select byte halves
// - never drive bus while device drives
`timescale 1ns/1ns
module asc_sram_host (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    req_valid,
    input  wire logic                    req_write,
    input  wire logic [asc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [asc_pkg::DATA_W-1:0] req_wdata,
    input  wire logic [1:0]              req_lanes,
    input  wire logic                    retain_req,
    output logic                         req_ready,
    output logic                         rsp_valid,
    output logic [asc_pkg::DATA_W-1:0]   rsp_rdata,
    output logic                         retain_ack,
    output logic                         sram_chip_sel_n,
    output logic                         sram_write_n,
    output logic                         sram_out_en_n,
    output logic                         lower_byte_lane_n,
    output logic                         upper_byte_lane_n,
    output logic [asc_pkg::ADDR_W-1:0]   sram_addr,
    output logic [asc_pkg::DATA_W-1:0]   sram_dq_out,
    output logic                         sram_dq_oe,
    input  wire logic [asc_pkg::DATA_W-1:0] sram_dq_in
);
    import asc_pkg::*;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        asc_state_t          state;
        logic                req_ready;
        logic                rsp_valid;
        logic [DATA_W-1:0]   rdata;
        logic                retain_ack;
        logic                cs_n;
        logic                we_n;
        logic                oe_n;
        logic                lb_n;
        logic                ub_n;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dq_out;
        logic                dq_oe;
        logic [1:0]          lanes;
        logic                pu_loaded;
    } asc_host_t;

    asc_host_t r;
    asc_host_t next_r;

    logic              cnt_load;
    logic [CNT_W-1:0]  cnt_value;
    logic              cnt_done;

    asc_delay_cnt asc_delay_cnt_inst (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .load  (cnt_load),
        .value (cnt_value),
        .done  (cnt_done)
    );

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n);
    endfunction : cyc

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        next_r          = r;
        next_r.rsp_valid = 1'b0;
        cnt_load        = 1'b0;
        cnt_value       = '0;
        case (r.state)
            ASC_POWER_UP: begin
                next_r.pu_loaded = 1'b1;
                if (!r.pu_loaded) begin
                    // first cycle after reset starts the supply-settle wait
                    cnt_load  = 1'b1;
                    cnt_value = cyc(POWER_UP_CYC);
                end else if (cnt_done) begin
                    next_r.state     = ASC_IDLE;
                    next_r.req_ready = 1'b1;
                end
            end
            ASC_IDLE: begin
                if (retain_req) begin
                    // select already high; retention only after that is seen
                    next_r.cs_n       = 1'b1;
                    next_r.retain_ack = 1'b1;
                    next_r.req_ready  = 1'b0;
                    next_r.state      = ASC_RETAIN;
                end else if (req_valid && req_lanes != 2'b00) begin
                    next_r.req_ready = 1'b0;
                    next_r.addr      = req_addr;
                    next_r.lanes     = req_lanes;
                    next_r.cs_n      = 1'b0;
                    next_r.lb_n      = ~req_lanes[0];
                    next_r.ub_n      = ~req_lanes[1];
                    cnt_load         = 1'b1;
                    if (req_write) begin
                        // strobe, select, lanes fall together to open the overlap
                        next_r.we_n   = 1'b0;
                        next_r.oe_n   = 1'b1;
                        next_r.dq_out = req_wdata;
                        next_r.dq_oe  = 1'b1;
                        cnt_value     = cyc(WR_LOW_CYC - 1);
                        next_r.state  = ASC_WRITE;
                    end else begin
                        next_r.we_n  = 1'b1;
                        next_r.oe_n  = 1'b0;
                        next_r.dq_oe = 1'b0;
                        cnt_value    = cyc(RD_WAIT_CYC - 1);
                        next_r.state = ASC_READ;
                    end
                end
            end
            ASC_WRITE: begin
                if (cnt_done) begin
                    // all controls rise on one edge; address and data stay
                    next_r.we_n  = 1'b1;
                    next_r.cs_n  = 1'b1;
                    next_r.lb_n  = 1'b1;
                    next_r.ub_n  = 1'b1;
                    cnt_load     = 1'b1;
                    cnt_value    = cyc(0);
                    next_r.state = ASC_TURN;
                end
            end
            ASC_READ: begin
                if (cnt_done) begin
                    next_r.rdata     = sram_dq_in;
                    if (!r.lanes[0]) begin
                        next_r.rdata[7:0] = 8'h00;
                    end
                    if (!r.lanes[1]) begin
                        next_r.rdata[15:8] = 8'h00;
                    end
                    next_r.rsp_valid = 1'b1;
                    next_r.oe_n      = 1'b1;
                    next_r.cs_n      = 1'b1;
                    next_r.lb_n      = 1'b1;
                    next_r.ub_n      = 1'b1;
                    cnt_load         = 1'b1;
                    cnt_value        = cyc(FLOAT_CYC - 1);
                    next_r.state     = ASC_TURN;
                end
            end
            ASC_TURN: begin
                // data released one cycle after the strobe rose, before drive
                next_r.dq_oe = 1'b0;
                if (cnt_done) begin
                    next_r.req_ready = 1'b1;
                    next_r.state     = ASC_IDLE;
                end
            end
            ASC_RETAIN: begin
                if (!retain_req) begin
                    next_r.retain_ack = 1'b0;
                    cnt_load          = 1'b1;
                    cnt_value         = cyc(RECOVER_CYC);
                    next_r.state      = ASC_RECOVER;
                end
            end
            ASC_RECOVER: begin
                if (cnt_done) begin
                    next_r.req_ready = 1'b1;
                    next_r.state     = ASC_IDLE;
                end
            end
            default: begin
                next_r.state = ASC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r       <= '0;
            r.state <= ASC_POWER_UP;
            r.cs_n  <= 1'b1;
            r.we_n  <= 1'b1;
            r.oe_n  <= 1'b1;
            r.lb_n  <= 1'b1;
            r.ub_n  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign req_ready         = r.req_ready;
    assign rsp_valid         = r.rsp_valid;
    assign rsp_rdata         = r.rdata;
    assign retain_ack        = r.retain_ack;
    assign sram_chip_sel_n   = r.cs_n;
    assign sram_write_n      = r.we_n;
    assign sram_out_en_n     = r.oe_n;
    assign lower_byte_lane_n = r.lb_n;
    assign upper_byte_lane_n = r.ub_n;
    assign sram_addr         = r.addr;
    assign sram_dq_out       = r.dq_out;
    assign sram_dq_oe        = r.dq_oe;
endmodule : asc_sram_host

/* File: tb/asc_monitor.sv */
// Purpose: pin protocol checks for the sram host controller
// Assumes: slow-grade cycle counts of asc_pkg
// Notes:   power-up count starts at raw reset release
`timescale 1ns/1ns
module asc_monitor (
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       req_valid,
    input wire logic [1:0]                 req_lanes,
    input wire logic                       retain_req,
    input wire logic                       req_ready,
    input wire logic                       retain_ack,
    input wire logic                       sram_chip_sel_n,
    input wire logic                       sram_write_n,
    input wire logic                       sram_out_en_n,
    input wire logic                       lower_byte_lane_n,
    input wire logic                       upper_byte_lane_n,
    input wire logic [asc_pkg::ADDR_W-1:0] sram_addr,
    input wire logic [asc_pkg::DATA_W-1:0] sram_dq_out,
    input wire logic                       sram_dq_oe
);
    import asc_pkg::*;
    logic [13:0] pu_cnt;
    wire lane_on = !(lower_byte_lane_n && upper_byte_lane_n);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // wait too long for a repetition, so count it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pu_cnt <= 14'h0000;
        else if (pu_cnt != 14'h3FFF) pu_cnt <= pu_cnt + 14'h0001;
    end
    power_up_wait_a:
    assert property (!sram_chip_sel_n |-> pu_cnt >= POWER_UP_CYC) else $error("select before power-up wait");
    write_start_a:
    assert property ($fell(sram_write_n) |-> !sram_chip_sel_n && lane_on && sram_dq_oe) else $error("bad write start");
    write_pulse_a:
    assert property ($fell(sram_write_n) |-> (!sram_write_n && !sram_chip_sel_n && lane_on)[*2]
        ##1 (sram_write_n && sram_chip_sel_n && !lane_on)) else $error("bad write pulse");
    write_hold_a:
    assert property (!sram_write_n && !$fell(sram_write_n) |-> $stable(sram_addr) && $stable(sram_dq_out))
        else $error("address or data moved in write");
    end_hold_a:
    assert property ($rose(sram_write_n) |-> $stable(sram_addr) && $stable(sram_dq_out) && sram_dq_oe)
        else $error("no hold at write end");
    bus_release_a:
    assert property ($rose(sram_write_n) |=> !sram_dq_oe) else $error("bus not released");
    read_strobe_a:
    assert property (!sram_out_en_n |-> sram_write_n) else $error("strobe low in read");
    no_contention_a:
    assert property (sram_dq_oe |-> sram_out_en_n) else $error("bus contention");
    read_wait_a:
    assert property ($fell(sram_out_en_n) |-> !sram_out_en_n[*3]) else $error("read too short");
    retain_select_a:
    assert property (retain_ack |-> sram_chip_sel_n) else $error("selected in retention");
    recovery_wait_a:
    assert property ($fell(retain_ack) |-> sram_chip_sel_n[*2]) else $error("recovery too short");
    lane_map_a:
    assert property (req_valid && req_ready && !retain_req && req_lanes != 2'h0
        |=> {upper_byte_lane_n, lower_byte_lane_n} == ~$past(req_lanes)) else $error("lane map wrong");
    cover property ($fell(sram_write_n));
    cover property ($fell(sram_out_en_n));
    cover property ($fell(retain_ack));
endmodule : asc_monitor
bind asc_sram_host asc_monitor asc_monitor_inst (.clk, .rst_n, .req_valid, .req_lanes, .retain_req, .req_ready,
    .retain_ack, .sram_chip_sel_n, .sram_write_n, .sram_out_en_n, .lower_byte_lane_n, .upper_byte_lane_n,
    .sram_addr, .sram_dq_out, .sram_dq_oe);

/* File: tb/asc_sram_model.sv */
// Purpose: behavioural async sram facing the host
// Assumes: slow-grade delays, no pulls on data lines
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ns
module asc_sram_model (
    input wire logic                       chip_sel_n,
    input wire logic                       write_n,
    input wire logic                       out_en_n,
    input wire logic                       lower_byte_lane_n,
    input wire logic                       upper_byte_lane_n,
    input wire logic [asc_pkg::ADDR_W-1:0] addr,
    input wire logic [asc_pkg::DATA_W-1:0] dq_wr,
    input wire logic                       host_drive,
    output logic     [asc_pkg::DATA_W-1:0] dq_rd
);
    import asc_pkg::*;
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] wr_d, word, rword;
    logic [ADDR_W-1:0] wr_a;
    logic [1:0]        wr_l = 2'h0;
    wire wr_on = !chip_sel_n && !write_n && !(lower_byte_lane_n && upper_byte_lane_n);
    wire rd_on = !chip_sel_n && !out_en_n && write_n;
    initial dq_rd = 16'h0000;
    // follow the overlap so whichever control rises first still commits
    always @* if (wr_on) begin
        wr_d = host_drive ? dq_wr : ~dq_wr;
        wr_a = addr;
        wr_l = {!upper_byte_lane_n, !lower_byte_lane_n};
    end
    always @(negedge wr_on) begin
        word = mem.exists(int'(wr_a)) ? mem[int'(wr_a)] : 16'h0000;
        if (wr_l[0]) word[7:0] = wr_d[7:0];
        if (wr_l[1]) word[15:8] = wr_d[15:8];
        mem[int'(wr_a)] = word;
    end
    always @(rd_on or lower_byte_lane_n or upper_byte_lane_n or addr) begin
        rword = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'h0000;
        if (rd_on && !lower_byte_lane_n) dq_rd[7:0] <= #7 rword[7:0];
        else dq_rd[7:0] <= #6 ~dq_rd[7:0];
        if (rd_on && !upper_byte_lane_n) dq_rd[15:8] <= #7 rword[15:8];
        else dq_rd[15:8] <= #6 ~dq_rd[15:8];
    end
endmodule : asc_sram_model

/* File: tb/asc_sram_host_tb_top.sv */
// Purpose: self-checking bench for the sram host controller
// Assumes: inputs driven on the falling clock edge
// Notes:   first request waits out the power-up time
`timescale 1ns/1ns
module asc_sram_host_tb_top;
    import asc_pkg::*;
    typedef struct {logic wr; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [1:0] l; logic [DATA_W-1:0] e;} asc_row_t;
    logic clk, rst_n, req_valid, req_write, retain_req, req_ready, rsp_valid, retain_ack, sram_dq_oe;
    logic sram_chip_sel_n, sram_write_n, sram_out_en_n, lower_byte_lane_n, upper_byte_lane_n;
    logic [ADDR_W-1:0] req_addr, sram_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, sram_dq_out, sram_dq_in;
    logic [1:0]        req_lanes;
    int                fails = 0;
    int                n_compared = 0;
    asc_row_t rows [7] = '{'{1'b1, 17'h00005, 16'h1234, 2'h3, 16'h0000}, '{1'b0, 17'h00005, 16'h0000, 2'h3, 16'h1234},
        '{1'b1, 17'h00005, 16'hABCD, 2'h1, 16'h0000}, '{1'b0, 17'h00005, 16'h0000, 2'h1, 16'h00CD},
        '{1'b0, 17'h00005, 16'h0000, 2'h2, 16'h1200}, '{1'b1, 17'h1FFFF, 16'h5600, 2'h2, 16'h0000},
        '{1'b0, 17'h1FFFF, 16'h0000, 2'h3, 16'h5600}};
    asc_sram_host asc_sram_host_inst (.clk, .rst_n, .req_valid, .req_write, .req_addr, .req_wdata, .req_lanes,
        .retain_req, .req_ready, .rsp_valid, .rsp_rdata, .retain_ack, .sram_chip_sel_n, .sram_write_n, .sram_out_en_n,
        .lower_byte_lane_n, .upper_byte_lane_n, .sram_addr, .sram_dq_out, .sram_dq_oe, .sram_dq_in);
    asc_sram_model asc_sram_model_inst (.chip_sel_n(sram_chip_sel_n), .write_n(sram_write_n), .out_en_n(sram_out_en_n),
        .lower_byte_lane_n, .upper_byte_lane_n, .addr(sram_addr), .dq_wr(sram_dq_out), .host_drive(sram_dq_oe),
        .dq_rd(sram_dq_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : check_bit
    // 0 ready, 1 read answer, 2 retention ack
    task automatic wait_sig(input int sel);
        int n;
        n = 0;
        while ((sel == 0 ? req_ready : sel == 1 ? rsp_valid : retain_ack) !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n == 20000) begin
            fails++;
            $display("CHECK FAILED at %0t: wait %0d timed out", $time, sel);
            report_and_stop();
        end
    endtask : wait_sig
    task automatic do_op(input asc_row_t r);
        wait_sig(0);
        req_valid = 1'b1;
        req_write = r.wr;
        req_addr = r.a;
        req_wdata = r.d;
        req_lanes = r.l;
        @(negedge clk);
        req_valid = 1'b0;
        if (!r.wr) begin
            wait_sig(1);
            check_word(rsp_rdata, r.e);
        end
        @(negedge clk);
    endtask : do_op
    initial begin
        {rst_n, req_valid, req_write, retain_req, req_lanes, req_addr, req_wdata} = '0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (100) @(negedge clk);
        check_bit(req_ready, 1'b0);
        foreach (rows[i]) do_op(rows[i]);
        wait_sig(0);
        req_valid = 1'b1;
        req_lanes = 2'h0;
        repeat (3) @(negedge clk);
        check_bit(sram_chip_sel_n, 1'b1);
        req_valid = 1'b0;
        retain_req = 1'b1;
        wait_sig(2);
        check_bit(sram_chip_sel_n, 1'b1);
        retain_req = 1'b0;
        @(negedge clk);
        check_bit(req_ready, 1'b0);
        do_op(rows[3]);
        rst_n = 1'b0;
        @(negedge clk);
        check_bit(sram_chip_sel_n, 1'b1);
        report_and_stop();
    end
endmodule : asc_sram_host_tb_top
